/* verilog/sof_defs.svh */
`ifndef SOF_DEFS_SVH
`define SOF_DEFS_SVH

`define SOF_ADDR_W         8
`define SOF_OFF_STATUS_ONE 8'h00
`define SOF_OFF_STATUS_TWO 8'h04
`define SOF_OFF_BYTE_BUF   8'h08
`define SOF_OFF_CONTROL    8'h0C

`define SOF_BIT_EVENT      7
`define SOF_BIT_TEN_BIT    6
`define SOF_BIT_DIR        5
`define SOF_BIT_BUSY       4
`define SOF_BIT_BYTE_DONE  3
`define SOF_BIT_MATCH      2
`define SOF_BIT_ROLE       1
`define SOF_BIT_START      0

`define SOF_CTL_ON         5
`define SOF_CTL_START      3
`define SOF_CTL_ACK        2
`define SOF_CTL_IRQ        0

`define SOF_STATUS_RESET   8'h00
`define SOF_CONTROL_RESET  8'h00

`endif

/* verilog/sof_pkg.sv */
package sof_pkg;
    // one-cycle event pulses from the shift datapath
    typedef struct packed {
        logic byte_tx_done;
        logic byte_rx_done;
        logic addr_acked;
        logic header_sent;
        logic addr_match;
        logic start_made;
    } sof_evt_type;

    // one-cycle error pulses from the second status register logic
    typedef struct packed {
        logic nack;
        logic halt;
        logic lost;
        logic misplaced;
    } sof_err_type;

    typedef struct packed {
        logic start_det;
        logic stop_det;
    } sof_cond_type;
endpackage

/* verilog/sof_line_watch.sv */
`timescale 1ns/1ps
`default_nettype none
module sof_line_watch (
    input  wire logic                  clk_i,
    input  wire logic                  rst_b_i,
    input  wire logic                  scl_i,
    input  wire logic                  sda_i,
    output var sof_pkg::sof_cond_type  cond_o
);
    import sof_pkg::*;

    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic       sda_last_reg;

    // pins are asynchronous to clk_i: two stages before any decode
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            sda_last_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_i};
            sda_sync_reg <= {sda_sync_reg[0], sda_i};
            sda_last_reg <= sda_sync_reg[1];
        end
    end

    // start: data falls while clock high; stop: data rises while clock high
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cond_o <= '0;
        end else begin
            cond_o.start_det <= scl_sync_reg[1] & sda_last_reg & ~sda_sync_reg[1];
            cond_o.stop_det  <= scl_sync_reg[1] & ~sda_last_reg & sda_sync_reg[1];
        end
    end
endmodule
`default_nettype wire

/* verilog/sof_flags.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sof_defs.svh"
module sof_flags #(
    parameter int ADDR_W = `SOF_ADDR_W
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_b_i,
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [ADDR_W-1:0]     paddr_i,
    input  wire logic [31:0]           pwdata_i,
    output logic      [31:0]           prdata_o,
    output logic                       pready_o,
    output logic                       pslverr_o,
    input  wire logic                  scl_i,
    input  wire logic                  sda_i,
    output logic                       scl_o,
    output logic                       scl_oe_b_o,
    input  wire sof_pkg::sof_evt_type  evt_i,
    input  wire sof_pkg::sof_err_type  err_i,
    input  wire logic                  global_mask_i,
    output logic                       interface_on_o,
    output logic                       start_req_o,
    output logic                       ack_en_o,
    output logic                       irq_o
);
    import sof_pkg::*;

    logic [1:0]   rst_sync_reg;
    logic         rst_b;
    sof_cond_type cond;
    logic         interface_on_reg;
    logic         irq_allow_reg;
    logic         start_req_reg;
    logic         ack_en_reg;
    logic         any_event_reg;
    logic         ten_bit_reg;
    logic         dir_reg;
    logic         busy_reg;
    logic         byte_done_reg;
    logic         match_reg;
    logic         role_reg;
    logic         start_sent_reg;
    logic         seq_one_reg;
    logic         seq_two_reg;
    logic [7:0]   status_one;
    logic         setup;
    logic         acc;
    logic         rd_one;
    logic         rd_two;
    logic         buf_acc;
    logic         buf_wr;
    logic         buf_rd;
    logic         other_rd;
    logic         one_done;
    logic         two_done;
    logic         any_evt;
    logic         stretch;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        hit = (a == ADDR_W'(off));
    endfunction

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_b = rst_sync_reg[1];

    sof_line_watch u_watch (
        .clk_i   (clk_i),
        .rst_b_i (rst_b),
        .scl_i   (scl_i),
        .sda_i   (sda_i),
        .cond_o  (cond)
    );

    assign setup    = psel_i & ~penable_i;
    assign acc      = psel_i & penable_i & pready_o;
    assign rd_one   = acc & ~pwrite_i & hit(paddr_i, `SOF_OFF_STATUS_ONE);
    assign rd_two   = acc & ~pwrite_i & hit(paddr_i, `SOF_OFF_STATUS_TWO);
    assign buf_acc  = acc & hit(paddr_i, `SOF_OFF_BYTE_BUF);
    assign buf_wr   = buf_acc & pwrite_i;
    assign buf_rd   = buf_acc & ~pwrite_i;
    assign other_rd = acc & ~pwrite_i & ~hit(paddr_i, `SOF_OFF_BYTE_BUF);
    assign one_done = seq_one_reg & buf_acc;
    assign two_done = seq_two_reg & buf_wr;
    assign any_evt  = evt_i.byte_tx_done | evt_i.byte_rx_done | evt_i.addr_match
                    | evt_i.start_made | evt_i.header_sent | evt_i.addr_acked
                    | err_i.nack | err_i.halt | err_i.lost | err_i.misplaced;
    assign stretch  = byte_done_reg | match_reg;

    assign status_one = {any_event_reg, ten_bit_reg, dir_reg, busy_reg,
                         byte_done_reg, match_reg, role_reg, start_sent_reg};

    // apb: no wait states; read data and pready both come from flops loaded in the setup cycle
    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            pready_o  <= setup;
            pslverr_o <= setup & ~(hit(paddr_i, `SOF_OFF_STATUS_ONE)
                       | hit(paddr_i, `SOF_OFF_STATUS_TWO)
                       | hit(paddr_i, `SOF_OFF_BYTE_BUF)
                       | hit(paddr_i, `SOF_OFF_CONTROL));
            if (setup && !pwrite_i) begin
                if (hit(paddr_i, `SOF_OFF_STATUS_ONE)) begin
                    prdata_o <= {24'h00_0000, status_one};
                end else if (hit(paddr_i, `SOF_OFF_CONTROL)) begin
                    prdata_o <= {26'h0, interface_on_reg, 2'h0,
                                 ack_en_reg, 1'b0, irq_allow_reg};
                end else begin
                    // status_two and byte_buffer data live outside this block
                    prdata_o <= 32'h0000_0000;
                end
            end
        end
    end

    // control register; the stop request is kept elsewhere and survives disable
    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            interface_on_reg <= 1'b0;
            irq_allow_reg    <= 1'b0;
            start_req_reg    <= 1'b0;
            ack_en_reg       <= 1'b0;
        end else if (acc && pwrite_i && hit(paddr_i, `SOF_OFF_CONTROL)) begin
            interface_on_reg <= pwdata_i[`SOF_CTL_ON];
            if (interface_on_reg && pwdata_i[`SOF_CTL_ON]) begin
                irq_allow_reg <= pwdata_i[`SOF_CTL_IRQ];
                start_req_reg <= pwdata_i[`SOF_CTL_START] & ~evt_i.start_made;
                ack_en_reg    <= pwdata_i[`SOF_CTL_ACK];
            end else begin
                // first enabling write only switches on
                irq_allow_reg <= 1'b0;
                start_req_reg <= 1'b0;
                ack_en_reg    <= 1'b0;
            end
        end else if (!interface_on_reg) begin
            irq_allow_reg <= 1'b0;
            start_req_reg <= 1'b0;
            ack_en_reg    <= 1'b0;
        end else if (evt_i.start_made) begin
            start_req_reg <= 1'b0;
        end
    end

    // sequence memory: a read of status_one or status_two arms, other reads disarm
    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            seq_one_reg <= 1'b0;
            seq_two_reg <= 1'b0;
        end else if (!interface_on_reg) begin
            seq_one_reg <= 1'b0;
            seq_two_reg <= 1'b0;
        end else begin
            if (rd_one) begin
                seq_one_reg <= 1'b1;
            end else if (other_rd || buf_acc) begin
                seq_one_reg <= 1'b0;
            end
            if (rd_two) begin
                seq_two_reg <= 1'b1;
            end else if (other_rd || buf_acc) begin
                seq_two_reg <= 1'b0;
            end
        end
    end

    // event summary: a new event in the clearing cycle wins
    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            any_event_reg <= 1'b0;
        end else if (!interface_on_reg) begin
            any_event_reg <= 1'b0;
        end else if (any_evt) begin
            any_event_reg <= 1'b1;
        end else if (rd_two || one_done || two_done) begin
            any_event_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            ten_bit_reg <= 1'b0;
        end else if (!interface_on_reg) begin
            ten_bit_reg <= 1'b0;
        end else if (evt_i.header_sent) begin
            ten_bit_reg <= 1'b1;
        end else if (two_done) begin
            ten_bit_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            byte_done_reg <= 1'b0;
            dir_reg       <= 1'b0;
        end else if (!interface_on_reg) begin
            byte_done_reg <= 1'b0;
            dir_reg       <= 1'b0;
        end else if (evt_i.byte_tx_done || evt_i.addr_acked) begin
            byte_done_reg <= 1'b1;
            dir_reg       <= 1'b1;
        end else if (evt_i.byte_rx_done) begin
            byte_done_reg <= 1'b1;
            dir_reg       <= 1'b0;
        end else if (one_done) begin
            byte_done_reg <= 1'b0;
            dir_reg       <= 1'b0;
        end else if (cond.stop_det || err_i.halt || err_i.lost) begin
            dir_reg       <= 1'b0;
        end
    end

    // busy keeps its value while off, so it may be stale after enabling
    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            busy_reg <= 1'b0;
        end else if (interface_on_reg) begin
            if (cond.stop_det || err_i.misplaced) begin
                busy_reg <= 1'b0;
            end else if (cond.start_det) begin
                busy_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            match_reg <= 1'b0;
        end else if (!interface_on_reg) begin
            match_reg <= 1'b0;
        end else if (evt_i.addr_match) begin
            match_reg <= 1'b1;
        end else if (rd_one) begin
            match_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            role_reg       <= 1'b0;
            start_sent_reg <= 1'b0;
        end else if (!interface_on_reg) begin
            role_reg       <= 1'b0;
            start_sent_reg <= 1'b0;
        end else begin
            if (evt_i.start_made && start_req_reg) begin
                role_reg <= 1'b1;
            end else if (cond.stop_det || err_i.lost) begin
                role_reg <= 1'b0;
            end
            if (evt_i.start_made) begin
                start_sent_reg <= 1'b1;
            end else if (one_done && buf_wr) begin
                start_sent_reg <= 1'b0;
            end
        end
    end

    // stretch follows the flags one cycle late; clock line is never driven high
    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            scl_o          <= 1'b0;
            scl_oe_b_o     <= 1'b1;
            irq_o          <= 1'b0;
            interface_on_o <= 1'b0;
            start_req_o    <= 1'b0;
            ack_en_o       <= 1'b0;
        end else begin
            scl_o          <= 1'b0;
            scl_oe_b_o     <= ~(interface_on_reg & stretch);
            irq_o          <= any_event_reg & irq_allow_reg & ~global_mask_i;
            interface_on_o <= interface_on_reg;
            start_req_o    <= start_req_reg;
            ack_en_o       <= ack_en_reg;
        end
    end

    AST_EVT_SET: assert property (@(posedge clk_i) disable iff (!rst_b)
        (interface_on_reg && any_evt) |=> any_event_reg)
        else $error("event summary not set after event");

    AST_TEN_CLR: assert property (@(posedge clk_i) disable iff (!rst_b)
        (ten_bit_reg && !seq_two_reg && buf_wr && !evt_i.header_sent
         && interface_on_reg) |=> ten_bit_reg)
        else $error("ten-bit flag cleared without status_two read");

    AST_DIR_TX: assert property (@(posedge clk_i) disable iff (!rst_b)
        (interface_on_reg && evt_i.byte_tx_done) |=> (dir_reg && byte_done_reg))
        else $error("direction not 1 after transmit");

    AST_DIR_CLR: assert property (@(posedge clk_i) disable iff (!rst_b)
        (!byte_done_reg && $past(cond.stop_det) && !$past(evt_i.byte_tx_done)
         && !$past(evt_i.addr_acked)) |-> !dir_reg)
        else $error("direction still set after stop");

    AST_BUSY_OFF: assert property (@(posedge clk_i) disable iff (!rst_b)
        !interface_on_reg |=> $stable(busy_reg))
        else $error("busy changed while off");

    AST_BUSY_ERR: assert property (@(posedge clk_i) disable iff (!rst_b)
        (interface_on_reg && err_i.misplaced) |=> !busy_reg)
        else $error("busy not cleared on misplaced condition");

    AST_BTF_SEQ: assert property (@(posedge clk_i) disable iff (!rst_b)
        (byte_done_reg && !seq_one_reg && buf_acc) |=> byte_done_reg)
        else $error("byte_done cleared without status_one read");

    AST_STRETCH: assert property (@(posedge clk_i) disable iff (!rst_b)
        (interface_on_reg && byte_done_reg) |=> !scl_oe_b_o)
        else $error("clock not stretched while byte_done set");

    AST_MATCH_HOLD: assert property (@(posedge clk_i) disable iff (!rst_b)
        (interface_on_reg && match_reg) [*2] |-> !scl_oe_b_o)
        else $error("clock released while slave_match set");

    AST_OFF_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_b)
        !interface_on_reg |=> (status_one & 8'hEF) == 8'h00)
        else $error("flags not cleared while off");

    AST_IRQ: assert property (@(posedge clk_i) disable iff (!rst_b)
        (any_event_reg && irq_allow_reg && !global_mask_i) |=> irq_o)
        else $error("interrupt not raised");
endmodule
`default_nettype wire

/* tb/sof_bus_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module sof_bus_peer (
    input  wire logic frame_i,
    input  wire logic scl_pull_b_i,
    output logic      scl_o,
    output logic      sda_o
);
    logic scl_drv;
    // open-drain wire with pull-up: low whenever either side pulls it
    assign scl_o = scl_drv & scl_pull_b_i;
    initial begin
        scl_drv = 1'b1;
        sda_o   = 1'b1;
        forever begin
            @(posedge frame_i);
            #40 sda_o = 1'b0;
            while (frame_i) begin
                #40 scl_drv = 1'b0;
                // data moves only while the clock is low, so no false conditions
                #40 sda_o = ~sda_o;
                #40 scl_drv = 1'b1;
                #40;
            end
            // clock stands still high between frames
            scl_drv = 1'b0;
            #40 sda_o = 1'b0;
            #40 scl_drv = 1'b1;
            #40 sda_o = 1'b1;
        end
    end
endmodule
`default_nettype wire

/* tb/sof_flags_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module sof_flags_tb_top;
    import sof_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        psel, penable, pwrite, gmask, frame, pready, pslverr, scl_oe_b, scl, sda;
    logic        on_o, st_o, ack_o, irq, e, sclo;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    sof_evt_type evt;
    sof_err_type err;
    int          n_mismatch = 0, tests_run = 0, seed = 17816, k;
    int          ev, tb, dir, busy, bd, mt, role, sb, c_on, c_st, c_ack, c_irq, arm1, arm2;

    always #10 clk_i = ~clk_i;

    sof_flags dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .scl_i(scl), .sda_i(sda), .scl_o(sclo),
        .scl_oe_b_o(scl_oe_b), .evt_i(evt), .err_i(err), .global_mask_i(gmask),
        .interface_on_o(on_o), .start_req_o(st_o), .ack_en_o(ack_o), .irq_o(irq));
    sof_bus_peer peer_u (.frame_i(frame), .scl_pull_b_i(scl_oe_b), .scl_o(scl), .sda_o(sda));

    task automatic conclude();
        if (n_mismatch == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] sr1();
        return {24'h0, 1'(ev), 1'(tb), 1'(dir), 1'(busy), 1'(bd), 1'(mt), 1'(role), 1'(sb)};
    endfunction

    task automatic model(input logic wr, input logic [7:0] a, input logic [31:0] d);
        if (a == 8'h00 && !wr) begin
            mt = 0; arm1 = 1; arm2 = 0;
        end else if (a == 8'h04 && !wr) begin
            ev = 0; arm2 = 1; arm1 = 0;
        end else if (a == 8'h08) begin
            if (arm1) begin
                bd = 0; dir = 0; ev = 0;
                if (wr) sb = 0;
            end
            if (arm2 && wr) begin
                tb = 0; ev = 0;
            end
            arm1 = 0; arm2 = 0;
        end else if (a == 8'h0C && wr) begin
            c_st = d[3]; c_ack = d[2]; c_irq = d[0];
            // only a write that finds the interface already on sets the other bits
            if (!c_on || !d[5]) {c_st, c_ack, c_irq} = 0;
            c_on = d[5];
            // busy is left as it was: it goes stale while off
            if (!c_on) {ev, tb, dir, bd, mt, role, sb, arm1, arm2} = 0;
        end else if (!wr) begin
            arm1 = 0; arm2 = 0;
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_mismatch++;
            conclude();
        end
        r = prdata; e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        model(wr, a, d);
    endtask

    task automatic obs();
        repeat (3) @(posedge clk_i);
        chk(32'(scl_oe_b), 32'(!(bd | mt) || !c_on));
        chk(32'(sclo), 32'h0);
        chk(32'(irq), 32'(ev && c_irq && !gmask));
        chk({on_o, st_o, ack_o}, {1'(c_on), 1'(c_st), 1'(c_ack)});
    endtask

    task automatic rs1();
        logic [31:0] x;
        x = sr1();
        apb(1'b0, 8'h00, 32'h0);
        chk(r, x);
        obs();
    endtask

    task automatic pulse(input int n);
        @(posedge clk_i);
        if (n < 6) evt <= sof_evt_type'(6'h20 >> n);
        else err <= sof_err_type'(4'h8 >> (n - 6));
        @(posedge clk_i);
        evt <= '0;
        err <= '0;
        case (n)
            0, 2: begin bd = 1; dir = 1; end
            1: begin bd = 1; dir = 0; end
            3: tb = 1;
            4: mt = 1;
            5: begin sb = 1; role = role | c_st; c_st = 0; end
            7: dir = 0;
            8: begin dir = 0; role = 0; end
            9: busy = 0;
            default: ;
        endcase
        ev = 1;
        obs();
    endtask

    task automatic bus(input logic f, input int cyc);
        @(posedge clk_i);
        frame <= f;
        repeat (cyc) @(posedge clk_i);
        if (c_on) busy = f;
    endtask

    initial begin
        {psel, penable, pwrite, gmask, frame} = '0;
        paddr = '0; pwdata = '0; evt = '0; err = '0;
        repeat (8) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rs1();
        apb(1'b0, 8'h10, 32'h0);
        chk(32'(e), 32'h1);
        bus(1'b1, 40);
        apb(1'b1, 8'h0C, 32'h2D);
        obs();
        rs1();
        bus(1'b0, 40);
        rs1();
        apb(1'b1, 8'h0C, 32'h2D);
        bus(1'b1, 30);
        rs1();
        pulse(9);
        rs1();
        bus(1'b0, 40);
        pulse(5); rs1(); apb(1'b1, 8'h08, 32'h0); rs1();
        pulse(0); rs1(); apb(1'b1, 8'h08, 32'h0); rs1();
        pulse(1); rs1(); apb(1'b0, 8'h08, 32'h0); rs1();
        pulse(3); apb(1'b0, 8'h04, 32'h0); apb(1'b1, 8'h08, 32'h0); rs1();
        pulse(6); apb(1'b0, 8'h04, 32'h0); rs1();
        pulse(0); rs1(); apb(1'b0, 8'h0C, 32'h0);
        chk(r, 32'((c_on << 5) | (c_st << 3) | (c_ack << 2) | c_irq));
        apb(1'b1, 8'h08, 32'h0); rs1();
        pulse(4); rs1(); rs1();
        for (int j = 0; j < 40; j++) begin
            k = ($random(seed) & 32'h7FFF) % 10;
            gmask <= 1'($random(seed));
            pulse(k);
            k = ($random(seed) & 32'h7FFF) % 4;
            if (k == 0) rs1();
            else apb(k == 3, (k == 1) ? 8'h04 : 8'h08, $random(seed));
            rs1();
        end
        pulse(2);
        apb(1'b1, 8'h0C, 32'h0);
        rs1();
        conclude();
    end

    initial begin
        #1ms;
        n_mismatch++;
        conclude();
    end
endmodule
`default_nettype wire
